// [hdl/bcc_exec.sv]
// Executor for bit clear, bit invert and accumulator invert instructions
`timescale 1ns/10ps
`include "bcc_exec_regs.svh"
// Function
// RULE_01 - Bit clear forces target bit to zero, other flags untouched.
// RULE_02 - Bit clear targets carry or any directly addressable bit.
// RULE_03 - Opcode C2 plus bit address byte clears that bit, one cycle.
// RULE_04 - Accumulator invert flips all eight bits, no flag changes.
// RULE_05 - Bit invert flips carry or addressed bit, other flags untouched.
// RULE_06 - Port bits invert from output latch value, never from pin.
// RULE_07 - Opcode B2 plus bit address byte inverts that bit, one cycle.
// RULE_08 - Opcodes C3, F4, B3 are one byte, one cycle forms.
module bcc_exec
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      fetch_valid,
    input  wire logic [7:0]                fetch_byte,
    input  wire logic                      bit_rd_latch,
    input  wire logic                      bit_rd_ram,
    output bcc_exec_pkg::bcc_bit_wr_t      bit_wr,
    output logic      [7:0]                bit_rd_addr,
    output logic      [7:0]                acc,
    output logic                           carry,
    output logic                           retire,
    output logic                           busy,
    output logic                           unknown_op
);
    bcc_exec_pkg::bcc_state_t   state_q;
    bcc_exec_pkg::bcc_state_t   state_d;
    bcc_exec_pkg::bcc_op_t      pend_q;
    bcc_exec_pkg::bcc_op_t      dec_op;
    bcc_exec_pkg::bcc_bit_wr_t  bit_wr_q;
    bcc_exec_pkg::bcc_bit_wr_t  bit_wr_d;
    logic [1:0]                 dec_len;
    logic [7:0]                 acc_q;
    logic [7:0]                 acc_d;
    logic                       carry_q;
    logic                       carry_d;
    logic                       retire_q;
    logic [7:0]                 rd_addr_q;
    logic [7:0]                 rd_addr_d;
    logic                       retire_d;
    logic                       busy_q;
    logic                       busy_d;
    logic                       unknown_q;
    logic                       unknown_d;

    bcc_opdec u_opdec
    (
        .opcode (fetch_byte),
        .op     (dec_op),
        .length (dec_len)
    );

    wire take_op      = fetch_valid && (state_q == bcc_exec_pkg::BCC_ST_OPCODE);
    wire take_addr    = fetch_valid && (state_q == bcc_exec_pkg::BCC_ST_OPERAND);
    wire two_byte     = (dec_len == `BCC_LEN_TWO);
    wire op_clr_carry = take_op && (dec_op == bcc_exec_pkg::BCC_OP_CLR_CARRY);
    wire op_inv_carry = take_op && (dec_op == bcc_exec_pkg::BCC_OP_INV_CARRY);
    wire op_inv_acc   = take_op && (dec_op == bcc_exec_pkg::BCC_OP_INV_ACC);
    wire op_none      = take_op && (dec_op == bcc_exec_pkg::BCC_OP_NONE);
    wire is_clr_bit   = take_addr && (pend_q == bcc_exec_pkg::BCC_OP_CLR_BIT);
    wire is_inv_bit   = take_addr && (pend_q == bcc_exec_pkg::BCC_OP_INV_BIT);
    // Bytes 80h and up are the special-function bit area, ports among them
    wire in_sfr_area  = (fetch_byte[7] == `BCC_BADDR_PORT);
    // Latch, not pin: a loaded pin must not corrupt the written value
    wire orig_bit     = in_sfr_area ? bit_rd_latch : bit_rd_ram; // RULE_06

    // Opcode byte opens a two-byte form; the next valid byte always closes it
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            bcc_exec_pkg::BCC_ST_OPCODE:
            begin
                if (take_op && two_byte)
                begin
                    state_d = bcc_exec_pkg::BCC_ST_OPERAND; // RULE_03 RULE_07
                end
            end
            bcc_exec_pkg::BCC_ST_OPERAND:
            begin
                if (take_addr)
                begin
                    state_d = bcc_exec_pkg::BCC_ST_OPCODE;
                end
            end
            default:
            begin
                state_d = bcc_exec_pkg::BCC_ST_OPCODE;
            end
        endcase
    end

    // Carry is the only flag this block touches
    assign carry_d = op_clr_carry ? 1'b0 :     // RULE_01 RULE_02
                     op_inv_carry ? ~carry_q : // RULE_05
                                    carry_q;

    assign acc_d = op_inv_acc ? ~acc_q : acc_q; // RULE_04

    assign bit_wr_d.valid = is_clr_bit || is_inv_bit; // RULE_02
    assign bit_wr_d.addr  = fetch_byte;
    assign bit_wr_d.value = is_inv_bit ? ~orig_bit : 1'b0; // RULE_01 RULE_05

    // Single-cycle completion: retire the cycle after the last byte
    assign retire_d  = (take_op && !two_byte && !op_none) || take_addr; // RULE_08
    assign unknown_d = op_none;
    assign busy_d    = (state_d == bcc_exec_pkg::BCC_ST_OPERAND);
    // Read address is the raw operand byte, kept for the bit space lookup
    assign rd_addr_d = take_addr ? fetch_byte : rd_addr_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= bcc_exec_pkg::BCC_ST_OPCODE;
            pend_q  <= bcc_exec_pkg::BCC_OP_NONE;
        end
        else
        begin
            state_q <= state_d;
            if (take_op)
            begin
                pend_q <= dec_op;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_q <= `BCC_ACC_RST;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            carry_q <= `BCC_CARRY_RST;
        end
        else
        begin
            carry_q <= carry_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_wr_q <= '0;
        end
        else
        begin
            bit_wr_q <= bit_wr_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            retire_q <= 1'b0;
        end
        else
        begin
            retire_q <= retire_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            unknown_q <= 1'b0;
        end
        else
        begin
            unknown_q <= unknown_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
        end
        else
        begin
            busy_q <= busy_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_addr_q <= `BCC_ADDR_RST;
        end
        else
        begin
            rd_addr_q <= rd_addr_d;
        end
    end

    assign bit_wr      = bit_wr_q;
    assign acc         = acc_q;
    assign carry       = carry_q;
    assign retire      = retire_q;
    assign busy        = busy_q;
    assign unknown_op  = unknown_q;
    assign bit_rd_addr = rd_addr_q;
endmodule

// [hdl/bcc_exec_pkg.sv]
// Types shared by the bit clear and invert executor
package bcc_exec_pkg;
    typedef enum logic [1:0] {
        BCC_ST_OPCODE = 2'b00,
        BCC_ST_OPERAND = 2'b01
    } bcc_state_t;

    typedef enum logic [2:0] {
        BCC_OP_NONE      = 3'b000,
        BCC_OP_CLR_BIT   = 3'b001,
        BCC_OP_CLR_CARRY = 3'b010,
        BCC_OP_INV_ACC   = 3'b011,
        BCC_OP_INV_CARRY = 3'b100,
        BCC_OP_INV_BIT   = 3'b101
    } bcc_op_t;

    // Write request toward the bit-addressable space
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic       value;
    } bcc_bit_wr_t;
endpackage

// [hdl/bcc_exec_regs.svh]
// Opcode, width and reset constants for the bit clear and invert executor
`ifndef BCC_EXEC_REGS_SVH
`define BCC_EXEC_REGS_SVH
`define BCC_OP_CLR_BIT   8'hC2
`define BCC_OP_CLR_CARRY 8'hC3
`define BCC_OP_INV_ACC   8'hF4
`define BCC_OP_INV_CARRY 8'hB3
`define BCC_OP_INV_BIT   8'hB2
`define BCC_LEN_ONE      2'h1
`define BCC_LEN_TWO      2'h2
`define BCC_ACC_RST      8'h00
`define BCC_CARRY_RST    1'b0
`define BCC_BADDR_PORT   1'b1
`define BCC_ADDR_RST     8'h00
`endif

// [hdl/bcc_opdec.sv]
// Opcode classifier for the bit clear and invert instructions
`timescale 1ns/10ps
`include "bcc_exec_regs.svh"
module bcc_opdec
(
    input  wire logic [7:0]           opcode,
    output bcc_exec_pkg::bcc_op_t     op,
    output logic      [1:0]           length
);
    wire is_clr_bit   = (opcode == `BCC_OP_CLR_BIT);
    wire is_clr_carry = (opcode == `BCC_OP_CLR_CARRY);
    wire is_inv_acc   = (opcode == `BCC_OP_INV_ACC);
    wire is_inv_carry = (opcode == `BCC_OP_INV_CARRY);
    wire is_inv_bit   = (opcode == `BCC_OP_INV_BIT);

    assign op = is_clr_bit   ? bcc_exec_pkg::BCC_OP_CLR_BIT :   // RULE_03
                is_clr_carry ? bcc_exec_pkg::BCC_OP_CLR_CARRY : // RULE_08
                is_inv_acc   ? bcc_exec_pkg::BCC_OP_INV_ACC :   // RULE_08
                is_inv_carry ? bcc_exec_pkg::BCC_OP_INV_CARRY : // RULE_08
                is_inv_bit   ? bcc_exec_pkg::BCC_OP_INV_BIT :   // RULE_07
                               bcc_exec_pkg::BCC_OP_NONE;
    assign length = (is_clr_bit || is_inv_bit) ? `BCC_LEN_TWO : `BCC_LEN_ONE;
endmodule

// [verification/bcc_exec_asserts.sv]
// Port checker for the bit clear and invert executor
`timescale 1ns/10ps
`include "bcc_exec_regs.svh"
module bcc_exec_asserts
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 fetch_valid,
    input wire logic [7:0]           fetch_byte,
    input wire logic                 bit_rd_latch,
    input wire logic                 bit_rd_ram,
    input bcc_exec_pkg::bcc_bit_wr_t bit_wr,
    input wire logic [7:0]           acc,
    input wire logic                 carry,
    input wire logic                 retire,
    input wire logic                 busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Remembers whether the pending operand belongs to a clear
    logic clr_q;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            clr_q <= 1'b0;
        else if (fetch_valid && !busy)
            clr_q <= fetch_byte == `BCC_OP_CLR_BIT;
    sequence op_s(logic [7:0] b);
        fetch_valid && !busy && fetch_byte == b;
    endsequence
    sequence arg_s;
        busy && fetch_valid;
    endsequence
    clr_c_a: assert property (op_s(`BCC_OP_CLR_CARRY) |=> retire && !carry && $stable(acc))
        else $error("carry clear");
    inv_acc_a: assert property (op_s(`BCC_OP_INV_ACC) |=> acc == ~$past(acc) && $stable(carry))
        else $error("acc invert");
    inv_c_a: assert property (op_s(`BCC_OP_INV_CARRY) |=> carry != $past(carry) && retire)
        else $error("carry invert");
    two_byte_a: assert property (fetch_valid && !busy && (fetch_byte == `BCC_OP_CLR_BIT
        || fetch_byte == `BCC_OP_INV_BIT) |=> busy && !retire)
        else $error("no operand wait");
    clr_bit_a: assert property (arg_s ##0 clr_q |=> bit_wr.valid && !bit_wr.value && $stable(carry))
        else $error("bit clear");
    bit_addr_a: assert property (arg_s |=> retire && !busy && bit_wr.addr == $past(fetch_byte))
        else $error("bit address");
    inv_port_a: assert property (arg_s ##0 !clr_q && fetch_byte[7] |=> bit_wr.value != $past(bit_rd_latch))
        else $error("latch invert");
    inv_ram_a: assert property (arg_s ##0 !clr_q && !fetch_byte[7] |=> bit_wr.value != $past(bit_rd_ram))
        else $error("ram invert");
endmodule
bind bcc_exec bcc_exec_asserts u_bcc_exec_asserts
(
    .core_clk     (core_clk),
    .rst          (rst),
    .fetch_valid  (fetch_valid),
    .fetch_byte   (fetch_byte),
    .bit_rd_latch (bit_rd_latch),
    .bit_rd_ram   (bit_rd_ram),
    .bit_wr       (bit_wr),
    .acc          (acc),
    .carry        (carry),
    .retire       (retire),
    .busy         (busy)
);

// [verification/bit_clear_complement_exec_test.sv]
// Self-checking bench for the bit clear and invert executor
`timescale 1ns/10ps
`include "bcc_exec_regs.svh"
module bit_clear_complement_exec_test;
    logic core_clk = 1'b0, rst = 1'b1, fetch_valid = 1'b0, bit_rd_latch = 1'b0, bit_rd_ram = 1'b0;
    logic [7:0]  fetch_byte = 8'h00, acc, acc_m = 8'h00, op, a;
    logic        carry, retire, busy, unknown_op, carry_m = 1'b0, v;
    bcc_exec_pkg::bcc_bit_wr_t bit_wr;
    logic [7:0]  ops[5] = '{`BCC_OP_CLR_BIT, `BCC_OP_CLR_CARRY, `BCC_OP_INV_ACC,
        `BCC_OP_INV_CARRY, `BCC_OP_INV_BIT};
    logic [19:0] note_q[$];
    logic [19:0] e_m;
    logic [7:0]  bit_rd_addr;
    int          fail_count = 0, cmp_count = 0, k;
    always #10 core_clk = ~core_clk;
    bcc_exec u_bcc_exec
    (
        .core_clk     (core_clk),
        .rst          (rst),
        .fetch_valid  (fetch_valid),
        .fetch_byte   (fetch_byte),
        .bit_rd_latch (bit_rd_latch),
        .bit_rd_ram   (bit_rd_ram),
        .bit_wr       (bit_wr),
        .bit_rd_addr  (bit_rd_addr),
        .acc          (acc),
        .carry        (carry),
        .retire       (retire),
        .busy         (busy),
        .unknown_op   (unknown_op)
    );
    task automatic put(input logic [7:0] b);
        fetch_valid = 1'b1;
        fetch_byte = b;
        @(posedge core_clk);
        #1;
    endtask
    task automatic gap();
        fetch_valid = 1'b0;
        fetch_byte = ~fetch_byte;
        @(posedge core_clk);
        #1;
    endtask
    // Bit write address and value only matter while valid
    task automatic cmp_res(input logic [19:0] e, input logic [19:0] g);
        cmp_count++;
        if (e[9] ? g !== e : g[19:9] !== e[19:9])
        begin
            fail_count++;
            $display("ERROR result expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_addr(input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR bit_rd_addr expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_busy(input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR busy expected %b seen %b", e, g);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Oldest note pairs with the next retire or refused opcode
    always @(negedge core_clk)
    begin
        if (retire === 1'b1 || unknown_op === 1'b1)
        begin
            if (note_q.size() == 0)
            begin
                fail_count++;
                $display("ERROR result expected none seen %h", {unknown_op, acc, carry, bit_wr});
            end
            else
            begin
                e_m = note_q.pop_front();
                cmp_res(e_m, {unknown_op, acc, carry, bit_wr});
                if (e_m[9])
                    cmp_addr(e_m[8:1], bit_rd_addr);
            end
        end
    end
    initial
    begin
        void'($urandom(22242));
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        cmp_res(20'h0, {unknown_op, acc, carry, bit_wr});
        for (int i = 0; i < 400; i++)
        begin
            k = $urandom % 6;
            op = (k < 5) ? ops[k] : 8'($urandom % 8'hB0);
            if (op == `BCC_OP_CLR_BIT || op == `BCC_OP_INV_BIT)
            begin
                put(op);
                if ($urandom % 2)
                    gap();
                cmp_busy(1'b1, busy);
                a = 8'($urandom);
                {bit_rd_latch, bit_rd_ram} = 2'($urandom);
                v = (op == `BCC_OP_CLR_BIT) ? 1'b0 : ~(a[7] ? bit_rd_latch : bit_rd_ram);
                note_q.push_back({1'b0, acc_m, carry_m, 1'b1, a, v});
                put(a);
                cmp_busy(1'b0, busy);
            end
            else
            begin
                carry_m = (op == `BCC_OP_CLR_CARRY) ? 1'b0 : carry_m ^ (op == `BCC_OP_INV_CARRY);
                acc_m = (op == `BCC_OP_INV_ACC) ? ~acc_m : acc_m;
                note_q.push_back({k == 5, acc_m, carry_m, 10'h000});
                put(op);
            end
            if ($urandom % 3 == 0)
                gap();
        end
        gap();
        gap();
        cmp_res(20'h0, {note_q.size() != 0, 19'h0});
        $display("random instruction test done");
        rst = 1'b1;
        #5;
        cmp_res(20'h0, {unknown_op, acc, carry, bit_wr});
        $display("reset test done");
        give_verdict();
    end
endmodule
